// ---- hw/cfs_pkg.sv ----
// Contract
// - Two sync acceptance window widths exist, a wide one for rotational disturbance and a narrow one, chosen by sync_window_select.
// - Loss of synchronisation is declared after a fixed forward protection count of 13 consecutive missed frame syncs.
// - A newly acquired frame sync is confirmed by a fixed backward protection count of 3 frames.
// - While locked, a missing expected sync is replaced by a substitute sync at the expected position, for up to 13 frames.
// - When sync has been missing for 13 frames the window opens and a new frame sync is searched for freely.
// - Right after resynchronisation, a missed sync within the 3 confirming frames reopens the window at once.
// - At normal speed one frame sync is expected about every 136 us (7.35 kHz) and the window is centred on that period.
// - A C1 codeword is 28 information bytes plus 4 parity bytes.
// - A C2 codeword is 24 information bytes plus 4 parity bytes.
// - Both levels decode Reed-Solomon codes of minimum distance 5.
// - Up to two symbol errors per C1 codeword and up to four per C2 codeword are corrected.
// - After C1 decoding a C1 pointer is attached, set from the C1 result, the EFM playback condition and the player state.
// - When the C2 pointer is high the sample is concealed by holding the previous value or by averaging its neighbours.
// - The correction result is shown as a 4-bit monitor code whose top bit is clear for C1 and set for C2 results.
// - C1 codes: 0000, 0001 pointer clear; 0100 to 0110 pointer set; 0111 uncorrectable; 0010 and 0011 unused.
// - C2 codes: 1000 to 1100 corrected; 1110 uncorrectable with C1 pointer copy; 1111 with C2 pointer set; 1101 unused.
package cfs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int              CFS_CLK_PERIOD_NS   = 10;
	localparam int              CFS_FRAME_PERIOD_NS = 136000;
	localparam int              CFS_TIMER_W         = 16;
	localparam logic [15:0]     CFS_FRAME_CYCLES    = 16'(CFS_FRAME_PERIOD_NS / CFS_CLK_PERIOD_NS);
	localparam logic [15:0]     CFS_WIN_NARROW      = 16'h0040;
	localparam logic [15:0]     CFS_WIN_WIDE        = 16'h0200;
	localparam logic [3:0]      CFS_FWD_PROTECT     = 4'hD;
	localparam logic [1:0]      CFS_BWD_PROTECT     = 2'h3;

	// ----------------------------------------------------------------
	// Code geometry and correction limits
	// ----------------------------------------------------------------
	localparam logic [7:0]      CFS_C1_INFO_BYTES   = 8'h1C;
	localparam logic [7:0]      CFS_C2_INFO_BYTES   = 8'h18;
	localparam logic [7:0]      CFS_PARITY_BYTES    = 8'h04;
	localparam logic [2:0]      CFS_RS_DMIN         = 3'h5;
	localparam logic [2:0]      CFS_C1_T            = 3'((CFS_RS_DMIN - 3'h1) >> 1);
	localparam logic [2:0]      CFS_C2_T            = 3'(CFS_RS_DMIN - 3'h1);
	localparam logic [4:0]      CFS_C2_COPY_LIMIT   = 5'h02;
	localparam int              CFS_SAMPLE_W        = 16;

	// ----------------------------------------------------------------
	// Monitor codes
	// ----------------------------------------------------------------
	localparam logic [3:0]      CFS_MON_C1_PTR_BASE = 4'h4;
	localparam logic [3:0]      CFS_MON_C1_FAIL     = 4'h7;
	localparam logic [3:0]      CFS_MON_C2_BASE     = 4'h8;
	localparam logic [3:0]      CFS_MON_C2_COPY     = 4'hE;
	localparam logic [3:0]      CFS_MON_C2_FAIL     = 4'hF;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]      CFS_REG_CTRL        = 8'h00;
	localparam logic [7:0]      CFS_REG_STATUS      = 8'h04;
	localparam logic [7:0]      CFS_REG_INT_STATUS  = 8'h08;
	localparam logic [7:0]      CFS_REG_INT_MASK    = 8'h0C;
	localparam logic [7:0]      CFS_REG_C2FAIL_CNT  = 8'h10;
	localparam logic [7:0]      CFS_REG_INSERT_CNT  = 8'h14;
	localparam logic [7:0]      CFS_REG_GEOMETRY    = 8'h18;
	localparam int              CFS_CTRL_SYNC_WINDOW_SELECT_BIT   = 0;
	localparam int              CFS_CTRL_INTERP_BIT = 1;
	localparam int              CFS_INT_LOCK_BIT    = 0;
	localparam int              CFS_INT_LOST_BIT    = 1;
	localparam int              CFS_INT_INSERT_BIT  = 2;
	localparam int              CFS_INT_C2FAIL_BIT  = 3;
	localparam logic [1:0]      CFS_CTRL_RST        = 2'h0;
	localparam logic [3:0]      CFS_INT_MASK_RST    = 4'h0;

	// Sync protection states.
	typedef enum logic [1:0] {
		CFS_SEARCH  = 2'b00,
		CFS_CONFIRM = 2'b01,
		CFS_LOCKED  = 2'b10
	} cfs_sync_t;

endpackage

// ---- hw/cfs_frame_ecc.sv ----
`timescale 1ns/1ps
`default_nettype none

module cfs_frame_ecc
	import cfs_pkg::*;
#(
	parameter logic [15:0] FRAME_CYCLES = CFS_FRAME_CYCLES,
	parameter logic [15:0] WIN_NARROW   = CFS_WIN_NARROW,
	parameter logic [15:0] WIN_WIDE     = CFS_WIN_WIDE
) (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Demodulator condition
	input  wire logic                    syncDetect,
	input  wire logic                    efmBad,
	input  wire logic                    playerUnstable,
	// C1 codeword result
	input  wire logic                    c1Done,
	input  wire logic [2:0]              c1Errors,
	// C2 codeword result
	input  wire logic                    c2Done,
	input  wire logic [2:0]              c2Errors,
	input  wire logic [4:0]              c2C1PtrCount,
	// Sample stream
	input  wire logic                    sampleValid,
	input  wire logic [CFS_SAMPLE_W-1:0] sampleIn,
	input  wire logic                    sampleC2Ptr,
	// Frame timing
	output logic                         frameStrobe,
	output logic                         syncInserted,
	output logic                         syncLocked,
	// Correction status
	output logic                         c1Pointer,
	output logic                         c2Pointer,
	output logic                         monitorValid,
	output logic                         correction_monitor_bit3,
	output logic                         correction_monitor_bit2,
	output logic                         correction_monitor_bit1,
	output logic                         correction_monitor_bit0,
	// Concealed samples
	output logic      [CFS_SAMPLE_W-1:0] sampleOut,
	output logic                         sampleOutValid,
	// Interrupt
	output logic                         irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------

	typedef struct packed {
		cfs_sync_t               syncState;
		logic [15:0]             frameTimer;
		logic [3:0]              missCount;
		logic [1:0]              backCount;
		logic                    substituted;
		logic [1:0]              ctrl;
		logic [3:0]              intStatus;
		logic [3:0]              intMask;
		logic [15:0]             c2FailCount;
		logic [15:0]             insertCount;
		logic [3:0]              monitorCode;
		logic                    monitorValid;
		logic                    c2Pending;
		logic [3:0]              c2PendCode;
		logic                    c2PendPtr;
		logic                    c1Pointer;
		logic                    c2Pointer;
		logic                    frameStrobe;
		logic                    syncInserted;
		logic [CFS_SAMPLE_W-1:0] prevSample;
		logic [CFS_SAMPLE_W-1:0] curSample;
		logic                    curErr;
		logic                    haveCur;
		logic [CFS_SAMPLE_W-1:0] sampleOut;
		logic                    sampleOutValid;
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
		logic                    irq;
	} cfs_state_t;

	cfs_state_t s_reg;
	cfs_state_t s_next;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Saturating increment for the event counters.
	function automatic logic [15:0] sat16(input logic [15:0] x);
		sat16 = (x == 16'hFFFF) ? x : x + 16'h0001;
	endfunction

	// Signed mean of two neighbouring samples.
	function automatic logic [CFS_SAMPLE_W-1:0] mean2(
		input logic [CFS_SAMPLE_W-1:0] a,
		input logic [CFS_SAMPLE_W-1:0] b
	);
		logic [CFS_SAMPLE_W:0] sum;
		sum   = {a[CFS_SAMPLE_W-1], a} + {b[CFS_SAMPLE_W-1], b};
		mean2 = sum[CFS_SAMPLE_W:1];
	endfunction

	// C1 monitor code from the error count and the pointer.
	function automatic logic [3:0] c1Code(input logic [2:0] errs, input logic ptr);
		if (errs > CFS_C1_T) begin
			c1Code = CFS_MON_C1_FAIL;
		end else if (ptr) begin
			c1Code = CFS_MON_C1_PTR_BASE | {2'b00, errs[1:0]};
		end else begin
			c1Code = {3'b000, errs[0]};
		end
	endfunction

	// ----------------------------------------------------------------
	// Combinational next state
	// ----------------------------------------------------------------

	logic [15:0] winHalf;
	logic        inWindow;
	logic        windowEnd;
	logic        apbAccess;
	logic        apbDone;
	logic        c1Ptr;
	logic [3:0]  c2CodeNow;
	logic        c2PtrNow;
	logic [3:0]  events;
	logic [CFS_SAMPLE_W-1:0] conceal;

	// Window width and position relative to the expected sync.
	always_comb begin
		winHalf   = s_reg.ctrl[CFS_CTRL_SYNC_WINDOW_SELECT_BIT] ? WIN_NARROW : WIN_WIDE;
		inWindow  = (s_reg.frameTimer >= FRAME_CYCLES - winHalf) &&
		            (s_reg.frameTimer <= FRAME_CYCLES + winHalf);
		windowEnd = (s_reg.frameTimer == FRAME_CYCLES + winHalf);
		apbAccess = psel && penable && !s_reg.pready;
		apbDone   = psel && penable && s_reg.pready;
	end

	// Correction classification for both levels.
	always_comb begin
		// The pointer marks doubtful frames before C2 sees them.
		c1Ptr = (c1Errors >= CFS_C1_T) || efmBad || playerUnstable ||
		        s_reg.substituted || (s_reg.syncState != CFS_LOCKED);
		if (c2Errors <= CFS_C2_T) begin
			c2CodeNow = CFS_MON_C2_BASE | {1'b0, c2Errors};
			c2PtrNow  = 1'b0;
		end else if (c2C1PtrCount <= CFS_C2_COPY_LIMIT) begin
			c2CodeNow = CFS_MON_C2_COPY;
			c2PtrNow  = 1'b0;
		end else begin
			c2CodeNow = CFS_MON_C2_FAIL;
			c2PtrNow  = 1'b1;
		end
	end

	// Concealment value for a sample flagged by its C2 pointer.
	always_comb begin
		if (s_reg.ctrl[CFS_CTRL_INTERP_BIT] && !sampleC2Ptr) begin
			conceal = mean2(s_reg.prevSample, sampleIn);
		end else begin
			conceal = s_reg.prevSample;
		end
	end

	// Main next-state process.
	always_comb begin
		s_next              = s_reg;
		events              = 4'h0;
		s_next.frameStrobe  = 1'b0;
		s_next.syncInserted = 1'b0;
		s_next.monitorValid = 1'b0;

		// Frame timer runs from the last real or substitute sync.
		if (s_reg.frameTimer != 16'hFFFF) begin
			s_next.frameTimer = s_reg.frameTimer + 16'h0001;
		end

		// Sync protection.
		case (s_reg.syncState)
			CFS_SEARCH: begin
				// Open window: any sync is taken as a candidate.
				if (syncDetect) begin
					s_next.syncState   = CFS_CONFIRM;
					s_next.frameTimer  = 16'h0000;
					s_next.backCount   = 2'h1;
					s_next.missCount   = 4'h0;
					s_next.substituted = 1'b0;
					s_next.frameStrobe = 1'b1;
				end
			end
			CFS_CONFIRM: begin
				if (syncDetect && inWindow) begin
					s_next.frameTimer  = 16'h0000;
					s_next.frameStrobe = 1'b1;
					s_next.backCount   = s_reg.backCount + 2'h1;
					if (s_reg.backCount == CFS_BWD_PROTECT - 2'h1) begin
						s_next.syncState = CFS_LOCKED;
						events[CFS_INT_LOCK_BIT] = 1'b1;
					end
				end else if (windowEnd) begin
					// No second chance while still confirming.
					s_next.syncState = CFS_SEARCH;
					s_next.backCount = 2'h0;
				end
			end
			CFS_LOCKED: begin
				if (syncDetect && inWindow) begin
					s_next.frameTimer  = 16'h0000;
					s_next.frameStrobe = 1'b1;
					s_next.missCount   = 4'h0;
					s_next.substituted = 1'b0;
				end else if (windowEnd) begin
					// Substitute sync keeps the frame grid where it was.
					s_next.frameTimer   = winHalf;
					s_next.frameStrobe  = 1'b1;
					s_next.syncInserted = 1'b1;
					s_next.substituted  = 1'b1;
					s_next.missCount    = s_reg.missCount + 4'h1;
					s_next.insertCount  = sat16(s_reg.insertCount);
					events[CFS_INT_INSERT_BIT] = 1'b1;
					if (s_reg.missCount == CFS_FWD_PROTECT - 4'h1) begin
						s_next.syncState = CFS_SEARCH;
						s_next.backCount = 2'h0;
						events[CFS_INT_LOST_BIT] = 1'b1;
					end
				end
			end
			default: begin
				s_next.syncState = CFS_SEARCH;
			end
		endcase

		// Monitor code; a C2 result that collides with C1 waits a cycle.
		if (c1Done) begin
			s_next.monitorCode  = c1Code(c1Errors, c1Ptr);
			s_next.monitorValid = 1'b1;
			s_next.c1Pointer    = c1Ptr || (c1Errors > CFS_C1_T);
		end else if (s_reg.c2Pending) begin
			s_next.monitorCode  = s_reg.c2PendCode;
			s_next.monitorValid = 1'b1;
			s_next.c2Pointer    = s_reg.c2PendPtr;
			s_next.c2Pending    = 1'b0;
		end else if (c2Done) begin
			s_next.monitorCode  = c2CodeNow;
			s_next.monitorValid = 1'b1;
			s_next.c2Pointer    = c2PtrNow;
		end
		if (c2Done && (c1Done || s_reg.c2Pending)) begin
			s_next.c2Pending  = 1'b1;
			s_next.c2PendCode = c2CodeNow;
			s_next.c2PendPtr  = c2PtrNow;
		end
		if (c2Done && (c2Errors > CFS_C2_T)) begin
			s_next.c2FailCount = sat16(s_reg.c2FailCount);
			events[CFS_INT_C2FAIL_BIT] = 1'b1;
		end

		// Sample path: one sample of delay so the next neighbour is known.
		s_next.sampleOutValid = 1'b0;
		if (s_reg.syncState == CFS_SEARCH) begin
			s_next.haveCur = 1'b0;
		end else if (sampleValid) begin
			s_next.curSample = sampleIn;
			s_next.curErr    = sampleC2Ptr;
			s_next.haveCur   = 1'b1;
			if (s_reg.haveCur) begin
				if (s_reg.curErr) begin
					s_next.sampleOut  = conceal;
					s_next.prevSample = conceal;
				end else begin
					s_next.sampleOut  = s_reg.curSample;
					s_next.prevSample = s_reg.curSample;
				end
				s_next.sampleOutValid = 1'b1;
			end
		end

		// APB: registered pready gives one wait state.
		s_next.pready  = apbAccess;
		s_next.pslverr = 1'b0;
		if (apbAccess) begin
			s_next.prdata = 32'h0000_0000;
			case (paddr)
				CFS_REG_CTRL: begin
					s_next.prdata = {30'h0, s_reg.ctrl};
				end
				CFS_REG_STATUS: begin
					s_next.prdata = {12'h0, s_reg.monitorCode, 6'h0, s_reg.backCount,
					                 s_reg.missCount, 2'h0, s_reg.syncState};
				end
				CFS_REG_INT_STATUS: begin
					s_next.prdata = {28'h0, s_reg.intStatus};
				end
				CFS_REG_INT_MASK: begin
					s_next.prdata = {28'h0, s_reg.intMask};
				end
				CFS_REG_C2FAIL_CNT: begin
					s_next.prdata = {16'h0, s_reg.c2FailCount};
				end
				CFS_REG_INSERT_CNT: begin
					s_next.prdata = {16'h0, s_reg.insertCount};
				end
				CFS_REG_GEOMETRY: begin
					// Code lengths as seen by the two decoder levels.
					s_next.prdata = {CFS_C1_INFO_BYTES + CFS_PARITY_BYTES,
					                 CFS_C2_INFO_BYTES + CFS_PARITY_BYTES,
					                 5'h0, CFS_RS_DMIN, 8'h0};
				end
				default: begin
					s_next.pslverr = 1'b1;
				end
			endcase
		end

		// Writes take effect on the edge that completes the transfer.
		s_next.intStatus = s_reg.intStatus;
		if (apbDone && pwrite) begin
			case (paddr)
				CFS_REG_CTRL: begin
					s_next.ctrl = pwdata[1:0];
				end
				CFS_REG_INT_STATUS: begin
					s_next.intStatus = s_reg.intStatus & ~pwdata[3:0];
				end
				CFS_REG_INT_MASK: begin
					s_next.intMask = pwdata[3:0];
				end
				default: begin
				end
			endcase
		end
		// A new event wins over a clear in the same cycle.
		s_next.intStatus = s_next.intStatus | events;
		s_next.irq       = |(s_next.intStatus & s_next.intMask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Synchronous reset leaves the block searching with the window open.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_reg           <= '0;
			s_reg.syncState <= CFS_SEARCH;
			s_reg.ctrl      <= CFS_CTRL_RST;
			s_reg.intMask   <= CFS_INT_MASK_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Every output except syncLocked, decoded from syncState, is taken straight from the state register.
	assign prdata                  = s_reg.prdata;
	assign pready                  = s_reg.pready;
	assign pslverr                 = s_reg.pslverr;
	assign frameStrobe             = s_reg.frameStrobe;
	assign syncInserted            = s_reg.syncInserted;
	assign syncLocked              = (s_reg.syncState == CFS_LOCKED);
	assign c1Pointer               = s_reg.c1Pointer;
	assign c2Pointer               = s_reg.c2Pointer;
	assign monitorValid            = s_reg.monitorValid;
	assign correction_monitor_bit3 = s_reg.monitorCode[3];
	assign correction_monitor_bit2 = s_reg.monitorCode[2];
	assign correction_monitor_bit1 = s_reg.monitorCode[1];
	assign correction_monitor_bit0 = s_reg.monitorCode[0];
	assign sampleOut               = s_reg.sampleOut;
	assign sampleOutValid          = s_reg.sampleOutValid;
	assign irq                     = s_reg.irq;

endmodule

`default_nettype wire

// ---- tb/cfs_frame_ecc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module cfs_frame_ecc_monitor
	import cfs_pkg::*;
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Bus handshake
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	// Decoder results and playback condition
	input wire logic       efmBad,
	input wire logic       playerUnstable,
	input wire logic       c1Done,
	input wire logic [2:0] c1Errors,
	input wire logic       c2Done,
	input wire logic [2:0] c2Errors,
	input wire logic [4:0] c2C1PtrCount,
	// Observed outputs
	input wire logic       frameStrobe,
	input wire logic       syncInserted,
	input wire logic       syncLocked,
	input wire logic       c1Pointer,
	input wire logic       c2Pointer,
	input wire logic       monitorValid,
	input wire logic       correction_monitor_bit3,
	input wire logic       correction_monitor_bit2,
	input wire logic       correction_monitor_bit1,
	input wire logic       correction_monitor_bit0
);
	logic [3:0] mon;
	logic [4:0] insCnt_reg;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------
	// Monitor code gathered from its four loose pins.
	assign mon = {correction_monitor_bit3, correction_monitor_bit2,
		correction_monitor_bit1, correction_monitor_bit0};

	// Counts substitutes since the last real accepted sync.
	always_ff @(posedge ref_clk) begin
		if (!rst_n || (frameStrobe && !syncInserted)) begin
			insCnt_reg <= 5'h00;
		end else if (syncInserted) begin
			insCnt_reg <= insCnt_reg + 5'h01;
		end
	end

	// ------------------------------------------------------------
	// Named steps and assertions
	// ------------------------------------------------------------
	// Access phase still waiting for its answer.
	sequence apbWait;
		psel && penable && !pready;
	endsequence
	// A second-level result that nothing else competes with.
	sequence c2Alone;
		c2Done && !c1Done && !$past(c2Done);
	endsequence

	AST_APB_WAIT: assert property (apbWait |=> pready)
		else $error("bus answer late");
	AST_INSERT_STROBE: assert property (syncInserted |-> frameStrobe)
		else $error("substitute without strobe");
	AST_INSERT_LOCKED: assert property (syncInserted && insCnt_reg < 5'h0C |-> syncLocked)
		else $error("lock lost early");
	AST_LOST: assert property (syncInserted && insCnt_reg == 5'h0C |-> ##[0:1] !syncLocked)
		else $error("lock kept too long");
	AST_LOCK_SYNC: assert property ($rose(syncLocked) |-> frameStrobe || $past(frameStrobe))
		else $error("lock without sync");
	AST_C1_FAIL: assert property (c1Done && c1Errors >= 3'h3 |=> monitorValid && mon == CFS_MON_C1_FAIL)
		else $error("C1 failure code wrong");
	AST_C1_PTR: assert property (c1Done && (efmBad || playerUnstable || c1Errors >= 3'h2)
		|=> c1Pointer && mon[3:2] == 2'h1)
		else $error("C1 pointer not set");
	AST_C2_CORR: assert property (c2Alone and c2Errors <= 3'h4
		|=> monitorValid && mon == {1'b1, c2Errors} && !c2Pointer)
		else $error("C2 corrected code wrong");
	AST_C2_FAIL: assert property (c2Alone and c2Errors > 3'h4 && c2C1PtrCount > CFS_C2_COPY_LIMIT
		|=> mon == CFS_MON_C2_FAIL && c2Pointer)
		else $error("C2 failure code wrong");
endmodule

bind cfs_frame_ecc cfs_frame_ecc_monitor uMonitor (.*);

`default_nettype wire

// ---- tb/cfs_demod_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module cfs_demod_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Control from the bench
	input  wire logic        run,
	input  wire logic [15:0] period,
	// Sync pulse toward the block
	output logic             syncDetect
);
	logic [15:0] tick;

	// Emits one sync pulse per period while running, none when stopped.
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !run) begin
			tick       <= 16'h0000;
			syncDetect <= 1'b0;
		end else begin
			tick       <= (tick == period - 16'h0001) ? 16'h0000 : tick + 16'h0001;
			syncDetect <= (tick == period - 16'h0001);
		end
	end
endmodule

`default_nettype wire

// ---- tb/cfs_frame_ecc_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module cfs_frame_ecc_tb_top
	import cfs_pkg::*;
;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        efmBad = 1'b0, playerUnstable = 1'b0, c1Done = 1'b0, c2Done = 1'b0;
	logic [2:0]  c1Errors = 3'h0, c2Errors = 3'h0;
	logic [4:0]  c2C1PtrCount = 5'h00;
	logic        sampleValid = 1'b0, sampleC2Ptr = 1'b0, run = 1'b0;
	logic [15:0] sampleIn = 16'h0000, period = 16'h00DC, sampleOut;
	logic        syncDetect, pready, pslverr, frameStrobe, syncInserted, syncLocked;
	logic        c1Pointer, c2Pointer, monitorValid, sampleOutValid, irq;
	logic [3:0]  mon;
	int          n_errors = 0, compares = 0;

	// Free-running 100 MHz clock.
	always #5 ref_clk = ~ref_clk;

	cfs_frame_ecc #(.FRAME_CYCLES(16'h00C8), .WIN_NARROW(16'h0008), .WIN_WIDE(16'h0020)) DUT (.*,
		.correction_monitor_bit3(mon[3]), .correction_monitor_bit2(mon[2]),
		.correction_monitor_bit1(mon[1]), .correction_monitor_bit0(mon[0]));
	cfs_demod_model uDemod (.*);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Compares one value and counts the result.
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// One bus transfer: setup, then access held until the answer edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) n_errors++;
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask
	// Waits for a lock change while counting pulses of one signal.
	task automatic waitLock(input logic lv, input logic useIns, output int s);
		int n;
		n = 0;
		s = 0;
		while (syncLocked !== lv && n < 5000) begin
			@(posedge ref_clk);
			s += useIns ? syncInserted : syncDetect;
			n++;
		end
	endtask
	// Sends one sample and returns the registered output two edges later.
	task automatic smp(input logic [15:0] d, input logic f, output logic [16:0] o);
		@(posedge ref_clk);
		sampleIn    <= d;
		sampleC2Ptr <= f;
		sampleValid <= 1'b1;
		@(posedge ref_clk);
		sampleValid <= 1'b0;
		@(posedge ref_clk);
		o = {sampleOutValid, sampleOut};
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] q;
		logic        e;
		rd(CFS_REG_GEOMETRY, q);
		chk("geometry", 32'h201C0500, q);
		rd(CFS_REG_STATUS, q);
		chk("status", 32'h0, q);
		apb(1'b1, 8'h40, 32'hFFFFFFFF, q, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk("unmapped data", 32'h0, q);
		rd(CFS_REG_INT_MASK, q);
		chk("mask", 32'h0, q);
	endtask
	// Period off by 20 cycles: refused by the narrow window, taken by the wide one.
	task automatic t_window();
		logic [31:0] q;
		int          s;
		wr(CFS_REG_CTRL, 32'h00000001);
		run <= 1'b1;
		cyc(1500);
		chk("narrow lock", 32'h0, {31'h0, syncLocked});
		run <= 1'b0;
		cyc(300);
		rd(CFS_REG_STATUS, q);
		chk("confirm dropped", 32'h0, {30'h0, q[1:0]});
		wr(CFS_REG_CTRL, 32'h00000000);
		run <= 1'b1;
		waitLock(1'b1, 1'b0, s);
		chk("syncs to lock", 32'h3, 32'(s));
		rd(CFS_REG_INT_STATUS, q);
		chk("lock event", 32'h1, q);
	endtask
	task automatic t_irq();
		logic [31:0] q;
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(CFS_REG_INT_MASK, 32'h1);
		cyc(2);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(CFS_REG_INT_STATUS, 32'h1);
		cyc(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd(CFS_REG_INT_STATUS, q);
		chk("status cleared", 32'h0, q);
	endtask
	// Every first- and second-level result with pointer causes.
	task automatic t_codes();
		logic [3:0] ex;
		for (int i = 0; i < 32; i++) begin
			@(posedge ref_clk);
			efmBad         <= i[0] & ~i[4];
			playerUnstable <= i[3] & ~i[4];
			c1Errors       <= {1'b0, i[2:1]};
			c2Errors       <= i[2:0];
			c2C1PtrCount   <= i[3] ? 5'h03 : 5'h02;
			c1Done         <= ~i[4];
			c2Done         <= i[4];
			@(posedge ref_clk);
			c1Done <= 1'b0;
			c2Done <= 1'b0;
			cyc(2);
			if (i[4]) ex = (i[2:0] <= 3'h4) ? {1'b1, i[2:0]} : (i[3] ? 4'hF : 4'hE);
			else if (i[2:1] == 2'h3) ex = 4'h7;
			else ex = (i[0] || i[3] || i[2]) ? {2'h1, i[2:1]} : {3'h0, i[1]};
			chk("monitor code", {28'h0, ex}, {28'h0, mon});
			chk("pointer", {31'h0, i[4] ? ex == 4'hF : ex[2]},
				{31'h0, i[4] ? c2Pointer : c1Pointer});
		end
	endtask
	task automatic t_samples();
		logic [16:0] o;
		for (int m = 0; m < 2; m++) begin
			wr(CFS_REG_CTRL, 32'(m * 2));
			smp(16'h0010, 1'b0, o);
			smp(16'h0BAD, 1'b1, o);
			chk("sample out", 32'h10010, 32'(o));
			smp(16'hFFDF, 1'b0, o);
			chk("concealed", (m == 1) ? 32'h1FFF7 : 32'h10010, 32'(o));
		end
	endtask
	task automatic t_loss();
		logic [31:0] q;
		int          s;
		run <= 1'b0;
		waitLock(1'b0, 1'b1, s);
		chk("substitutes", 32'hD, 32'(s));
		rd(CFS_REG_INSERT_CNT, q);
		chk("insert count", 32'hD, q);
		rd(CFS_REG_INT_STATUS, q);
		chk("loss events", 32'h6, q & 32'h6);
		rd(CFS_REG_STATUS, q);
		chk("searching", 32'h0, {30'h0, q[1:0]});
	endtask

	// ------------------------------------------------------------
	// Sequence and verdict
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Main run after six reset cycles.
	initial begin
		cyc(6);
		rst_n <= 1'b1;
		t_regs();
		t_window();
		t_irq();
		t_codes();
		t_samples();
		t_loss();
		end_of_test();
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		#300000;
		n_errors++;
		end_of_test();
	end
endmodule

`default_nettype wire
